// file: src/rhsp_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and an asynchronous active-high reset.
 */
module rhsp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              do_wr = in_valid && in_ready;
	wire              do_rd = out_valid && out_ready;
	wire [AW:0]       fill  = wr_ptr - rd_ptr;

	assign in_ready  = (fill != DEPTH[AW:0]);
	assign out_valid = (fill != '0);
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW+1)'(do_wr);
			rd_ptr <= rd_ptr + (AW+1)'(do_rd);
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
		fill <= DEPTH[AW:0]) else $error("fifo fill above depth");
endmodule // rhsp_fifo

// file: src/rhsp_pkg.sv
/*
 * types shared by the serial slave port files.
 * assumes rhsp_regs.svh in the include path.
 */
`include "rhsp_regs.svh"
package rhsp_pkg;
	typedef logic [`RHSP_WORD_BITS-1:0] rhsp_word_t;
	typedef logic [`RHSP_CNT_BITS-1:0]  rhsp_cnt_t;
endpackage

// file: src/rhsp_regs.svh
/*
 * constants of the host serial slave port: word size, fifo depth, widths.
 * assumes inclusion by the package and design files under one guard.
 */
`ifndef RHSP_REGS_SVH
`define RHSP_REGS_SVH
`define RHSP_WORD_BITS   16
`define RHSP_CNT_BITS    5
`define RHSP_FIFO_DEPTH  32
`define RHSP_RESET_WORD  16'h0000
`endif

// file: src/rhsp_slave.sv
/*
 * serial slave port: 16-bit full-duplex words framed by select.
 * received words queue in a fifo toward the user; transmit word is
 * taken from tx_data/tx_valid at frame start. serial pins are
 * asynchronous and resynchronised on clk (serial clock <= clk/8).
 */
`include "rhsp_regs.svh"
module rhsp_slave #(
	parameter int FIFO_DEPTH = `RHSP_FIFO_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        host_serial_clock,
	input  wire logic        select_n,
	input  wire logic        host_to_device_line,
	output logic             device_to_host_line,
	output logic             device_to_host_oe,
	input  wire rhsp_pkg::rhsp_word_t tx_data,
	input  wire logic        tx_valid,
	output logic             tx_taken,
	output rhsp_pkg::rhsp_word_t rx_data,
	output logic             rx_valid,
	input  wire logic        rx_ready,
	output logic             overrun,
	output logic             frame_error
);
	import rhsp_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sck_s;
	logic [1:0] sel_s;
	logic [1:0] din_s;
	logic       sck_d;
	logic       sel_d;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sck_s <= 2'h0;
			sel_s <= 2'h3;
			din_s <= 2'h0;
			sck_d <= 1'b0;
			sel_d <= 1'b1;
		end else begin
			sck_s <= {sck_s[0], host_serial_clock};
			sel_s <= {sel_s[0], select_n};
			din_s <= {din_s[0], host_to_device_line};
			sck_d <= sck_s[1];
			sel_d <= sel_s[1];
		end
	end
	wire sck_rise  = sck_s[1] && !sck_d;
	wire sck_fall  = !sck_s[1] && sck_d;
	wire sel_act   = !sel_s[1];
	wire frm_start = !sel_s[1] && sel_d;
	wire frm_end   = sel_s[1] && !sel_d;

	// ------------------------------------------------------------
	// shift engine
	// ------------------------------------------------------------
	rhsp_word_t rx_shift;
	rhsp_word_t tx_shift;
	rhsp_cnt_t  bit_cnt;
	logic       word_done;
	logic       over_seen;
	wire        got_16  = (bit_cnt == rhsp_cnt_t'(`RHSP_WORD_BITS));
	wire        in_bit  = sel_act && sck_rise && !got_16;
	wire        out_bit = sel_act && sck_fall && (bit_cnt != '0) && !got_16;
	wire        extra_edge = sel_act && sck_rise && got_16;
	wire        fifo_in_ready;
	wire        push    = frm_end && got_16 && !over_seen;
	rhsp_word_t next_rx_shift;
	assign next_rx_shift = {rx_shift[`RHSP_WORD_BITS-2:0], din_s[1]};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_shift <= `RHSP_RESET_WORD;
			bit_cnt  <= '0;
		end else if (frm_start) begin
			bit_cnt <= '0;
		end else if (in_bit) begin
			rx_shift <= next_rx_shift;
			bit_cnt  <= bit_cnt + rhsp_cnt_t'(1);
		end
	end

	// a 17th rising edge spoils the word although 16 bits were counted
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			over_seen <= 1'b0;
		else if (frm_start)
			over_seen <= 1'b0;
		else if (extra_edge)
			over_seen <= 1'b1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_shift <= `RHSP_RESET_WORD;
			tx_taken <= 1'b0;
		end else begin
			tx_taken <= frm_start && tx_valid;
			if (frm_start)
				tx_shift <= tx_valid ? tx_data : `RHSP_RESET_WORD;
			else if (out_bit)
				tx_shift <= {tx_shift[`RHSP_WORD_BITS-2:0], 1'b0};
		end
	end

	// output only moves at frame start or after a falling edge
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			device_to_host_line <= 1'b0;
			device_to_host_oe   <= 1'b0;
		end else begin
			device_to_host_oe <= sel_act;
			if (frm_start)
				device_to_host_line <= tx_valid ?
					tx_data[`RHSP_WORD_BITS-1] : 1'b0;
			else if (out_bit)
				device_to_host_line <= tx_shift[`RHSP_WORD_BITS-2];
		end
	end

	// a short or overlong frame is dropped and flagged
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			word_done   <= 1'b0;
			overrun     <= 1'b0;
			frame_error <= 1'b0;
		end else begin
			word_done   <= push;
			overrun     <= push && !fifo_in_ready;
			frame_error <= (frm_end && !got_16) ||
				extra_edge;
		end
	end

	// ------------------------------------------------------------
	// receive queue
	// ------------------------------------------------------------
	rhsp_word_t fifo_out_data;
	logic       fifo_out_valid;
	wire        user_take = rx_valid && rx_ready;
	wire        fifo_pop  = fifo_out_valid && (!rx_valid || user_take);
	rhsp_fifo #(
		.WIDTH(`RHSP_WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_data   (rx_shift),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop)
	);
	// output stage keeps rx outputs straight from flops
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_valid <= 1'b0;
			rx_data  <= `RHSP_RESET_WORD;
		end else if (fifo_pop) begin
			rx_valid <= 1'b1;
			rx_data  <= fifo_out_data;
		end else if (user_take) begin
			rx_valid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	out_hold_a: assert property (!sck_fall && !frm_start
		|=> $stable(device_to_host_line))
		else $error("outbound line moved without falling edge");
	rx_capture_a: assert property (in_bit
		|=> rx_shift[0] == $past(din_s[1]))
		else $error("inbound bit not captured");
	bit_count_a: assert property (in_bit
		|=> bit_cnt == $past(bit_cnt) + rhsp_cnt_t'(1))
		else $error("bit counter missed a bit");
	word_push_a: assert property (push && fifo_in_ready
		|=> word_done && !overrun)
		else $error("complete word not queued");
	short_frame_a: assert property (frm_end && !got_16
		|=> frame_error && !word_done)
		else $error("short frame not flagged");
	idle_float_a: assert property (sel_s[1] ##1 sel_s[1]
		|=> !device_to_host_oe)
		else $error("outbound line driven while deselected");
	frame_msb_a: assert property (frm_start && tx_valid
		|=> device_to_host_line == $past(tx_data[`RHSP_WORD_BITS-1]))
		else $error("msb not presented first");
	start_clear_a: assert property (frm_start |=> bit_cnt == '0)
		else $error("bit counter not cleared at frame start");
	over_drop_a: assert property (frm_end && over_seen
		|=> !word_done && !overrun)
		else $error("overlong frame was queued");
	rx_hold_a: assert property (rx_valid && !rx_ready
		|=> rx_valid && $stable(rx_data))
		else $error("received word lost before it was taken");
	oe_follow_a: assert property (sel_act ##1 sel_act
		|=> device_to_host_oe)
		else $error("outbound line not driven during frame");
	taken_pulse_a: assert property (tx_taken |=> !tx_taken)
		else $error("transmit word taken twice in one frame");
	cnt_cap_a: assert property (got_16 && !frm_start
		|=> got_16)
		else $error("bit counter passed the word size");

	word_cov: cover property (push ##1 word_done);
	over_cov: cover property (frm_end && over_seen);
	full_cov: cover property (overrun);
	err_cov:  cover property (frame_error);
	rx_cov:   cover property (rx_valid && rx_ready);
endmodule // rhsp_slave

// file: verif/rhsp_host.sv
/*
 * host serial master model: frames words with select, clock idles low.
 * assumes the bench clock paces it, eight clk per serial period.
 */
module rhsp_host (
	input  wire logic clk,
	output logic      host_serial_clock,
	output logic      select_n,
	output logic      host_to_device_line,
	input  wire logic device_to_host_line
);
	timeunit 1ns;
	timeprecision 1ns;
	int stab_err = 0;
	initial begin
		host_serial_clock = 1'b0;
		select_n = 1'b1;
		host_to_device_line = 1'b0;
	end
	task automatic half();
		repeat (4) @(negedge clk);
	endtask
	// n other than 16 breaks framing on purpose
	task automatic xfer(input rhsp_pkg::rhsp_word_t w, input int n,
		output rhsp_pkg::rhsp_word_t got);
		rhsp_pkg::rhsp_word_t sh;
		logic b;
		got = '0;
		sh = w;
		@(negedge clk);
		select_n = 1'b0;
		host_to_device_line = sh[15];
		repeat (4) half();
		for (int i = 0; i < n; i++) begin
			host_serial_clock = 1'b1;
			b = device_to_host_line;
			got = {got[14:0], b};
			half();
			if (device_to_host_line !== b) stab_err++;
			host_serial_clock = 1'b0;
			sh = sh << 1;
			host_to_device_line = sh[15];
			half();
		end
		select_n = 1'b1;
		// released line must not keep its last value
		host_to_device_line = ~host_to_device_line;
		repeat (2) half();
	endtask
endmodule // rhsp_host

// file: verif/tb_radar_host_spi_slave_port.sv
/*
 * self-checking bench of the serial slave port.
 * assumes rhsp_pkg, rhsp_slave and the host model rhsp_host.
 */
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_radar_host_spi_slave_port;
	timeunit 1ns;
	timeprecision 1ns;
	import rhsp_pkg::*;
	logic       clk = 1'b0, reset = 1'b1, tx_valid = 1'b0, rx_ready = 1'b0;
	rhsp_word_t tx_data = '0, rx_data, got;
	logic       sclk, sel_n, mosi, miso, oe, taken, rx_valid, ovr, ferr;
	int         failures = 0, compares = 0, fe_n = 0, ov_n = 0, tk_n = 0;
	int         cyc = 0, base;
	// undriven line shows the inverse, so a late or missing enable shows up
	wire        miso_pin = oe ? miso : ~miso;
	always #25 clk = ~clk;
	rhsp_slave DUT (.clk(clk), .reset(reset), .host_serial_clock(sclk),
		.select_n(sel_n), .host_to_device_line(mosi),
		.device_to_host_line(miso), .device_to_host_oe(oe),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_taken(taken),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.overrun(ovr), .frame_error(ferr));
	rhsp_host host (.clk(clk), .host_serial_clock(sclk), .select_n(sel_n),
		.host_to_device_line(mosi), .device_to_host_line(miso_pin));
	always @(posedge clk) begin
		cyc++;
		if (ferr === 1'b1) fe_n++;
		if (ovr === 1'b1) ov_n++;
		if (taken === 1'b1) tk_n++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic pop(input rhsp_word_t e);
		for (int i = 0; i < 20 && rx_valid !== 1'b1; i++) @(negedge clk);
		`CHK("rx_valid", 1'b1, rx_valid)
		`CHK("rx_data", e, rx_data)
		rx_ready = 1'b1;
		@(negedge clk);
		rx_ready = 1'b0;
	endtask
	// -------------------------------------------------------------
	// scenarios
	// -------------------------------------------------------------
	task automatic t_words();
		rhsp_word_t w [2] = '{16'hA5C3, 16'h3C5A};
		tx_valid = 1'b1;
		foreach (w[i]) begin
			tx_data = w[i];
			base = tk_n;
			host.xfer(~w[i], 16, got);
			`CHK("tx_word", w[i], got)
			`CHK("taken", base + 1, tk_n)
			`CHK("oe_idle", 1'b0, oe)
			pop(~w[i]);
		end
		tx_valid = 1'b0;
		host.xfer(16'h8001, 16, got);
		`CHK("zeros", 16'h0000, got)
		pop(16'h8001);
		`CHK("stable", 0, host.stab_err)
	endtask
	task automatic t_bad();
		base = fe_n;
		host.xfer(16'h1234, 15, got);
		host.xfer(16'h4321, 17, got);
		`CHK("frame_err", base + 2, fe_n)
		`CHK("no_word", 1'b0, rx_valid)
	endtask
	task automatic t_fifo();
		// 32 queued plus one in the output stage: the 34th word is dropped
		for (int i = 0; i < 34; i++) host.xfer(16'h0100 + i[15:0], 16, got);
		`CHK("overrun", 1, ov_n)
		for (int i = 0; i < 33; i++) pop(16'h0100 + i[15:0]);
		`CHK("drained", 1'b0, rx_valid)
	endtask
	initial begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		`CHK("oe_reset", 1'b0, oe)
		t_words();
		t_bad();
		t_fifo();
		conclude();
	end
endmodule // tb_radar_host_spi_slave_port
